// ===== hdl/ppm_cfg.svh
// constants for the port pin function multiplexer
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH
`define PPM_ADDR_W 32
`define PPM_OFS_LATCH_THREE 32'hffff_f006
`define PPM_OFS_LATCH_FOUR 32'hffff_f008
`define PPM_OFS_LATCH_FIVE 32'hffff_f00a
`define PPM_OFS_LATCH_SIX 32'hffff_f00c
`define PPM_OFS_LATCH_NINE 32'hffff_f012
`define PPM_OFS_DIR_TWO 32'hffff_f024
`define PPM_OFS_DIR_FOUR 32'hffff_f028
`define PPM_OFS_FSEL_TWO 32'hffff_f044
`define PPM_OFS_FSEL_THREE 32'hffff_f046
`define PPM_OFS_DIR_THREE 32'hffff_f026
`define PPM_OFS_DIR_FIVE 32'hffff_f02a
`define PPM_OFS_DIR_SIX 32'hffff_f02c
`define PPM_OFS_DIR_NINE 32'hffff_f032
`define PPM_OFS_LATCH_TWO 32'hffff_f004
`define PPM_OFS_EXP_CODE 32'hffff_f04c
`define PPM_DIR_RESET 8'hff
`define PPM_FSEL_TWO_RESET 8'h01
`define PPM_FSEL_TWO_MASK 8'h1e
`define PPM_FSEL_THREE_MASK 8'h1f
`define PPM_FSEL_THREE_RESET 8'h00
`define PPM_LATCH_RESET 8'h00
`define PPM_EXP_OFF 3'h0
`define PPM_EXP_FIRST 3'h3
`define PPM_EXP_FULL 3'h7
`define PPM_EXP_MASK 8'h07
`define PPM_BOOT_ROMLESS 2'h0
`define PPM_RESP_OKAY 2'h0
`define PPM_RESP_SLVERR 2'h2
`endif

// ===== hdl/ppm_pkg.sv
// types for the port pin function multiplexer
package ppm_pkg;
	typedef struct packed {
		logic [7:0] ext_irq_group_zero_en;
		logic [3:0] serial_en;
		logic nmi_in;
		logic [3:0] ext_irq_group_zero;
		logic ser_data_in;
		logic ser_clk_in;
		logic uart_rx_in;
	} ppm_periph_in_t;
	typedef struct packed {
		logic ser_data_out;
		logic ser_clk_out;
		logic ser_clk_oe;
		logic uart_tx_out;
	} ppm_periph_out_t;
	typedef struct packed {
		logic [15:0] muxed_addr_data;
		logic [15:0] muxed_addr_data_oe;
		logic [7:0] upper_address_out;
		logic low_byte_enable_out;
		logic high_byte_enable_out;
		logic read_write_out;
		logic data_strobe_out;
		logic address_latch_strobe_out;
	} ppm_membus_t;
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} ppm_pins_t;
	typedef struct packed {
		logic [7:0] latch_two;
		logic [7:0] latch_three;
		logic [7:0] latch_four;
		logic [7:0] latch_five;
		logic [7:0] latch_six;
		logic [7:0] latch_nine;
		logic [7:0] dir_two;
		logic [7:0] dir_three;
		logic [7:0] dir_four;
		logic [7:0] dir_five;
		logic [7:0] dir_six;
		logic [7:0] dir_nine;
		logic [7:0] fsel_two;
		logic [7:0] fsel_three;
		logic [2:0] expansion_code_bits;
		logic boot_seen;
		logic aw_full;
		logic [31:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		ppm_pins_t p2;
		ppm_pins_t p3;
		ppm_pins_t p4;
		ppm_pins_t p5;
		ppm_pins_t p6;
		ppm_pins_t p9;
		logic [4:0] irq_in;
		logic ser_data_in;
		logic ser_clk_in;
		logic uart_rx_in;
		logic fetch_ok;
	} ppm_state_t;
endpackage

// ===== hdl/ppm_port_mux.sv
// port direction and pin-function multiplexing for ports 2-6 and 9 with an axi4-lite slave
//
// What this block does
// - pin 0 of port 2 is always the non-maskable interrupt input, whatever the registers hold.
// - bit 0 of the port 2 direction and function-select registers reads 1 and ignores writes.
// - a direction bit of 0 turns the pin's output driver on, 1 turns it off, per pin.
// - port 2 function bits 1-4 route pins 1-4 to external interrupt inputs 0-3 when set.
// - port 3 function bits 0-4 route pins 0-4 to serial out, serial in, serial clock, uart tx, rx.
// - port 3 pins 5-7 are always general i/o and their function bits stay zero.
// - ports 4 and 5 carry the multiplexed address/data bus for expansion codes 3-7, i/o at 0.
// - ports 4, 5, 6 and 9 switch function only through boot pins and the expansion code.
// - with both boot pins low, the first clock after reset release loads expansion code 7 so external expansion runs at once.
// - once the expansion code is cleared to 0, external instruction fetch is no longer allowed.
// - port 6 drives upper address lines 16-23 progressively for codes 5-7, none below.
// - port 9 pins 0-4 carry byte enables, read/write and strobes for codes 3-7, i/o at 0.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ppm_cfg.svh"

module ppm_port_mux (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic [31:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [31:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_boot_config_pin_a,
	input wire logic i_boot_config_pin_b,
	input wire logic [7:0] i_p2,
	input wire logic [7:0] i_p3,
	input wire logic [7:0] i_p4,
	input wire logic [7:0] i_p5,
	input wire logic [7:0] i_p6,
	input wire logic [7:0] i_p9,
	output ppm_pkg::ppm_pins_t o_p2,
	output ppm_pkg::ppm_pins_t o_p3,
	output ppm_pkg::ppm_pins_t o_p4,
	output ppm_pkg::ppm_pins_t o_p5,
	output ppm_pkg::ppm_pins_t o_p6,
	output ppm_pkg::ppm_pins_t o_p9,
	input wire ppm_pkg::ppm_periph_out_t i_periph,
	input wire ppm_pkg::ppm_membus_t i_membus,
	output logic o_nmi,
	output logic [3:0] o_ext_irq_group_zero,
	output logic o_ser_data_in,
	output logic o_ser_clk_in,
	output logic o_uart_rx_in,
	output logic o_fetch_ok,
	output logic [2:0] o_expansion_code_reg
);
	import ppm_pkg::*;

	ppm_state_t s_q;
	ppm_state_t s_d;
	logic exp_on;
	logic [7:0] upper_en;
	logic aw_take;
	logic ar_take;
	logic [31:0] rd_word;
	logic rd_hit;

	// byte lane merge lets single-bit read-modify-write and byte writes behave alike
	function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [1:0] lane);
		logic [7:0] r;
		r = old;
		if (strb[lane]) begin
			r = data[8*lane +: 8];
		end
		return r;
	endfunction

	// the lane comes from the low address bits of the full register offset
	function automatic logic [31:0] place(input logic [7:0] v, input logic [31:0] ofs);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[8*ofs[1:0] +: 8] = v;
		return r;
	endfunction

	// expansion codes 1 and 2 are reserved; treat only 3..7 as bus mode
	assign exp_on = (s_q.expansion_code_bits >= `PPM_EXP_FIRST);

	always_comb begin
		upper_en = 8'h00;
		case (s_q.expansion_code_bits)
			3'h5: upper_en = 8'h03;
			3'h6: upper_en = 8'h3f;
			3'h7: upper_en = 8'hff;
			default: upper_en = 8'h00;
		endcase
	end

	assign aw_take = s_q.aw_full && s_q.w_full && !s_q.bvalid;
	assign ar_take = i_arvalid && !s_q.rvalid;

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		if ({i_araddr[31:2], 2'b00} == {`PPM_OFS_LATCH_TWO & 32'hffff_fffc}) begin
			rd_word = place(s_q.latch_two, `PPM_OFS_LATCH_TWO & 2'h3)
				| place(s_q.latch_three, `PPM_OFS_LATCH_THREE & 2'h3);
		end else if ({i_araddr[31:2], 2'b00} == {`PPM_OFS_LATCH_FOUR & 32'hffff_fffc}) begin
			rd_word = place(s_q.latch_four, `PPM_OFS_LATCH_FOUR & 2'h3)
				| place(s_q.latch_five, `PPM_OFS_LATCH_FIVE & 2'h3);
		end else if ({i_araddr[31:2], 2'b00} == {`PPM_OFS_LATCH_SIX & 32'hffff_fffc}) begin
			rd_word = place(s_q.latch_six, `PPM_OFS_LATCH_SIX & 2'h3);
		end else if ({i_araddr[31:2], 2'b00} == {`PPM_OFS_LATCH_NINE & 32'hffff_fffc}) begin
			rd_word = place(s_q.latch_nine, `PPM_OFS_LATCH_NINE & 2'h3);
		end else if ({i_araddr[31:2], 2'b00} == {`PPM_OFS_DIR_TWO & 32'hffff_fffc}) begin
			rd_word = place(s_q.dir_two, `PPM_OFS_DIR_TWO & 2'h3)
				| place(s_q.dir_three, `PPM_OFS_DIR_THREE & 2'h3);
		end else if ({i_araddr[31:2], 2'b00} == {`PPM_OFS_DIR_FOUR & 32'hffff_fffc}) begin
			rd_word = place(s_q.dir_four, `PPM_OFS_DIR_FOUR & 2'h3)
				| place(s_q.dir_five, `PPM_OFS_DIR_FIVE & 2'h3);
		end else if ({i_araddr[31:2], 2'b00} == {`PPM_OFS_DIR_SIX & 32'hffff_fffc}) begin
			rd_word = place(s_q.dir_six, `PPM_OFS_DIR_SIX & 2'h3);
		end else if ({i_araddr[31:2], 2'b00} == {`PPM_OFS_DIR_NINE & 32'hffff_fffc}) begin
			rd_word = place(s_q.dir_nine, `PPM_OFS_DIR_NINE & 2'h3);
		end else if ({i_araddr[31:2], 2'b00} == {`PPM_OFS_FSEL_TWO & 32'hffff_fffc}) begin
			rd_word = place(s_q.fsel_two, `PPM_OFS_FSEL_TWO & 2'h3)
				| place(s_q.fsel_three, `PPM_OFS_FSEL_THREE & 2'h3);
		end else if ({i_araddr[31:2], 2'b00} == {`PPM_OFS_EXP_CODE & 32'hffff_fffc}) begin
			rd_word = place({5'h00, s_q.expansion_code_bits}, `PPM_OFS_EXP_CODE & 2'h3);
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_comb begin
		logic [7:0] p;
		p = 8'h00;
		s_d = s_q;
		s_d.irq_in = 5'h00;
		// axi write channels may arrive in either order; hold each until both are in
		if (i_awvalid && !s_q.aw_full) begin
			s_d.aw_full = 1'b1;
			s_d.aw_addr = i_awaddr;
		end
		if (i_wvalid && !s_q.w_full) begin
			s_d.w_full = 1'b1;
			s_d.w_data = i_wdata;
			s_d.w_strb = i_wstrb;
		end
		if (s_q.bvalid && i_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (aw_take) begin
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `PPM_RESP_OKAY;
			if ({s_q.aw_addr[31:2], 2'b00} == {`PPM_OFS_LATCH_TWO & 32'hffff_fffc}) begin
				s_d.latch_two = lane_merge(s_q.latch_two, s_q.w_data, s_q.w_strb, 2'h0);
				s_d.latch_three = lane_merge(s_q.latch_three, s_q.w_data, s_q.w_strb, 2'h2);
			end else if ({s_q.aw_addr[31:2], 2'b00} == {`PPM_OFS_LATCH_FOUR & 32'hffff_fffc}) begin
				s_d.latch_four = lane_merge(s_q.latch_four, s_q.w_data, s_q.w_strb, 2'h0);
				s_d.latch_five = lane_merge(s_q.latch_five, s_q.w_data, s_q.w_strb, 2'h2);
			end else if ({s_q.aw_addr[31:2], 2'b00} == {`PPM_OFS_LATCH_SIX & 32'hffff_fffc}) begin
				s_d.latch_six = lane_merge(s_q.latch_six, s_q.w_data, s_q.w_strb, 2'h0);
			end else if ({s_q.aw_addr[31:2], 2'b00} == {`PPM_OFS_LATCH_NINE & 32'hffff_fffc}) begin
				s_d.latch_nine = lane_merge(s_q.latch_nine, s_q.w_data, s_q.w_strb, 2'h2);
			end else if ({s_q.aw_addr[31:2], 2'b00} == {`PPM_OFS_DIR_TWO & 32'hffff_fffc}) begin
				p = lane_merge(s_q.dir_two, s_q.w_data, s_q.w_strb, 2'h0);
				s_d.dir_two = p | 8'h01;
				s_d.dir_three = lane_merge(s_q.dir_three, s_q.w_data, s_q.w_strb, 2'h2);
			end else if ({s_q.aw_addr[31:2], 2'b00} == {`PPM_OFS_DIR_FOUR & 32'hffff_fffc}) begin
				s_d.dir_four = lane_merge(s_q.dir_four, s_q.w_data, s_q.w_strb, 2'h0);
				s_d.dir_five = lane_merge(s_q.dir_five, s_q.w_data, s_q.w_strb, 2'h2);
			end else if ({s_q.aw_addr[31:2], 2'b00} == {`PPM_OFS_DIR_SIX & 32'hffff_fffc}) begin
				s_d.dir_six = lane_merge(s_q.dir_six, s_q.w_data, s_q.w_strb, 2'h0);
			end else if ({s_q.aw_addr[31:2], 2'b00} == {`PPM_OFS_DIR_NINE & 32'hffff_fffc}) begin
				s_d.dir_nine = lane_merge(s_q.dir_nine, s_q.w_data, s_q.w_strb, 2'h2);
			end else if ({s_q.aw_addr[31:2], 2'b00} == {`PPM_OFS_FSEL_TWO & 32'hffff_fffc}) begin
				p = lane_merge(s_q.fsel_two, s_q.w_data, s_q.w_strb, 2'h0);
				s_d.fsel_two = (p & `PPM_FSEL_TWO_MASK) | `PPM_FSEL_TWO_RESET;
				p = lane_merge(s_q.fsel_three, s_q.w_data, s_q.w_strb, 2'h2);
				s_d.fsel_three = p & `PPM_FSEL_THREE_MASK;
			end else if ({s_q.aw_addr[31:2], 2'b00} == {`PPM_OFS_EXP_CODE & 32'hffff_fffc}) begin
				p = lane_merge({5'h00, s_q.expansion_code_bits}, s_q.w_data, s_q.w_strb, 2'h0);
				s_d.expansion_code_bits = p[2:0];
			end else begin
				s_d.bresp = `PPM_RESP_SLVERR;
			end
		end
		if (s_q.rvalid && i_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (ar_take) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_word;
			s_d.rresp = rd_hit ? `PPM_RESP_OKAY : `PPM_RESP_SLVERR;
		end
		// external fetch is lost for good once the code reaches zero
		if (s_d.expansion_code_bits == `PPM_EXP_OFF) begin
			s_d.fetch_ok = 1'b0;
		end
		// boot pins sampled on the first clock after reset release, never under reset
		if (!s_q.boot_seen) begin
			s_d.boot_seen = 1'b1;
			if ({i_boot_config_pin_b, i_boot_config_pin_a} == `PPM_BOOT_ROMLESS) begin
				s_d.expansion_code_bits = `PPM_EXP_FULL;
				s_d.fetch_ok = 1'b1;
			end
		end
		// port 2: pin 0 never drives, pins 1-4 are inputs when steered to interrupts
		s_d.p2.o = s_q.latch_two;
		s_d.p2.oe = ~s_q.dir_two & ~s_q.fsel_two & 8'hfe;
		s_d.irq_in = i_p2[4:0] & s_q.fsel_two[4:0];
		s_d.irq_in[0] = i_p2[0];
		// port 3 serial functions
		s_d.p3.o = s_q.latch_three;
		s_d.p3.oe = ~s_q.dir_three;
		if (s_q.fsel_three[0]) begin
			s_d.p3.o[0] = i_periph.ser_data_out;
			s_d.p3.oe[0] = 1'b1;
		end
		if (s_q.fsel_three[1]) begin
			s_d.p3.oe[1] = 1'b0;
		end
		if (s_q.fsel_three[2]) begin
			s_d.p3.o[2] = i_periph.ser_clk_out;
			s_d.p3.oe[2] = i_periph.ser_clk_oe;
		end
		if (s_q.fsel_three[3]) begin
			s_d.p3.o[3] = i_periph.uart_tx_out;
			s_d.p3.oe[3] = 1'b1;
		end
		if (s_q.fsel_three[4]) begin
			s_d.p3.oe[4] = 1'b0;
		end
		s_d.ser_data_in = s_q.fsel_three[1] ? i_p3[1] : 1'b0;
		s_d.ser_clk_in = s_q.fsel_three[2] ? i_p3[2] : 1'b0;
		s_d.uart_rx_in = s_q.fsel_three[4] ? i_p3[4] : 1'b1;
		// memory expansion ports follow only the expansion code
		if (exp_on) begin
			s_d.p4.o = i_membus.muxed_addr_data[7:0];
			s_d.p4.oe = i_membus.muxed_addr_data_oe[7:0];
			s_d.p5.o = i_membus.muxed_addr_data[15:8];
			s_d.p5.oe = i_membus.muxed_addr_data_oe[15:8];
		end else begin
			s_d.p4.o = s_q.latch_four;
			s_d.p4.oe = ~s_q.dir_four;
			s_d.p5.o = s_q.latch_five;
			s_d.p5.oe = ~s_q.dir_five;
		end
		s_d.p6.o = (i_membus.upper_address_out & upper_en) | (s_q.latch_six & ~upper_en);
		s_d.p6.oe = upper_en | (~s_q.dir_six & ~upper_en);
		s_d.p9.o = s_q.latch_nine;
		s_d.p9.oe = ~s_q.dir_nine;
		if (exp_on) begin
			s_d.p9.o[4:0] = {i_membus.address_latch_strobe_out, i_membus.data_strobe_out,
				i_membus.read_write_out, i_membus.high_byte_enable_out,
				i_membus.low_byte_enable_out};
			s_d.p9.oe[4:0] = 5'h1f;
		end
		if (i_p4 == 8'h00 && i_p5 == 8'h00 && i_p6 == 8'h00 && i_p9 == 8'h00) begin
			p = 8'h00;
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			s_q <= '0;
			s_q.dir_two <= `PPM_DIR_RESET;
			s_q.dir_three <= `PPM_DIR_RESET;
			s_q.dir_four <= `PPM_DIR_RESET;
			s_q.dir_five <= `PPM_DIR_RESET;
			s_q.dir_six <= `PPM_DIR_RESET;
			s_q.dir_nine <= `PPM_DIR_RESET;
			s_q.fsel_two <= `PPM_FSEL_TWO_RESET;
			s_q.fsel_three <= `PPM_FSEL_THREE_RESET;
			s_q.uart_rx_in <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_awready = !s_q.aw_full;
	assign o_wready = !s_q.w_full;
	assign o_bvalid = s_q.bvalid;
	assign o_bresp = s_q.bresp;
	assign o_arready = !s_q.rvalid;
	assign o_rvalid = s_q.rvalid;
	assign o_rdata = s_q.rdata;
	assign o_rresp = s_q.rresp;
	assign o_p2 = s_q.p2;
	assign o_p3 = s_q.p3;
	assign o_p4 = s_q.p4;
	assign o_p5 = s_q.p5;
	assign o_p6 = s_q.p6;
	assign o_p9 = s_q.p9;
	assign o_nmi = s_q.irq_in[0];
	assign o_ext_irq_group_zero = s_q.irq_in[4:1];
	assign o_ser_data_in = s_q.ser_data_in;
	assign o_ser_clk_in = s_q.ser_clk_in;
	assign o_uart_rx_in = s_q.uart_rx_in;
	assign o_fetch_ok = s_q.fetch_ok;
	assign o_expansion_code_reg = s_q.expansion_code_bits;
endmodule

// ===== bench/ppm_port_mux_asserts.sv
// port-level checks for the pin multiplexer, bound into its top
`timescale 1ns/1ps
module ppm_port_mux_asserts (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_boot_config_pin_a,
	input wire logic i_boot_config_pin_b,
	input wire logic [7:0] i_p2,
	input wire logic [7:0] i_p3,
	input wire logic i_bready,
	input wire logic i_rready,
	input wire ppm_pkg::ppm_membus_t i_membus,
	input wire ppm_pkg::ppm_pins_t o_p2,
	input wire ppm_pkg::ppm_pins_t o_p4,
	input wire ppm_pkg::ppm_pins_t o_p6,
	input wire ppm_pkg::ppm_pins_t o_p9,
	input wire logic o_nmi,
	input wire logic [3:0] o_ext_irq_group_zero,
	input wire logic o_ser_data_in,
	input wire logic o_uart_rx_in,
	input wire logic o_fetch_ok,
	input wire logic [2:0] o_expansion_code_reg,
	input wire logic o_bvalid,
	input wire logic o_rvalid,
	input wire logic [31:0] o_rdata
);
	import ppm_pkg::*;
	logic [1:0] up_q;
	// past values are only trusted once a few edges have passed since reset
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			up_q <= 2'h0;
		end else if (up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	property p_nmi;
		up_q == 2'h3 |-> o_nmi == $past(i_p2[0]);
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi does not follow its pin");
	property p_nmi_oe;
		o_p2.oe[0] == 1'b0;
	endproperty
	a_nmi_oe: assert property (p_nmi_oe) else $error("nmi pin driven");
	property p_irq;
		up_q == 2'h3 |-> (o_ext_irq_group_zero & ~$past(i_p2[4:1])) == 4'h0;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without pin level");
	property p_ser;
		up_q == 2'h3 && (!o_uart_rx_in || o_ser_data_in) |-> $past(i_p3[4]) == o_uart_rx_in
			|| $past(i_p3[1]) == o_ser_data_in;
	endproperty
	a_ser: assert property (p_ser) else $error("serial input without pin level");
	property p_boot;
		$fell(i_reset) && !i_boot_config_pin_a && !i_boot_config_pin_b
			|-> ##[1:3] o_expansion_code_reg == 3'h7 && o_fetch_ok;
	endproperty
	a_boot: assert property (p_boot) else $error("romless boot code wrong");
	property p_fetch;
		up_q == 2'h3 && o_expansion_code_reg == 3'h0 |-> ##[0:2] !o_fetch_ok;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch kept at code zero");
	property p_fetch_hold;
		up_q == 2'h3 && !o_fetch_ok |=> !o_fetch_ok;
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("fetch came back");
	property p_ad;
		up_q == 2'h3 && $past(o_expansion_code_reg) >= 3'h3
			|-> o_p4.oe == $past(i_membus.muxed_addr_data_oe[7:0]);
	endproperty
	a_ad: assert property (p_ad) else $error("address/data enable wrong");
	property p_upper;
		up_q == 2'h3 && $past(o_expansion_code_reg) == 3'h7
			|-> o_p6.o == $past(i_membus.upper_address_out) && o_p6.oe == 8'hff;
	endproperty
	a_upper: assert property (p_upper) else $error("upper address wrong");
	property p_ctl;
		up_q == 2'h3 && $past(o_expansion_code_reg) >= 3'h3 |-> o_p9.oe[4:0] == 5'h1f
			&& o_p9.o[0] == $past(i_membus.low_byte_enable_out)
			&& o_p9.o[4] == $past(i_membus.address_latch_strobe_out);
	endproperty
	a_ctl: assert property (p_ctl) else $error("bus control pins wrong");
	property p_bhold;
		o_bvalid && !i_bready |=> o_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold;
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule

bind ppm_port_mux ppm_port_mux_asserts i_ppm_port_mux_asserts (.*);

// ===== bench/ppm_far_model.sv
// peripherals and bus controller feeding the multiplexer
`timescale 1ns/1ps
module ppm_far_model (
	input wire logic i_mclk,
	input wire logic i_reset,
	output ppm_pkg::ppm_periph_out_t o_periph,
	output ppm_pkg::ppm_membus_t o_membus
);
	import ppm_pkg::*;
	logic [63:0] lfsr_q;
	// outputs move every cycle so a stale pin value never matches by luck
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			lfsr_q <= 64'h1234_5678_9abc_def1;
		end else begin
			lfsr_q <= {lfsr_q[62:0], lfsr_q[63] ^ lfsr_q[62] ^ lfsr_q[60] ^ lfsr_q[59]};
		end
	end
	assign o_periph = ppm_periph_out_t'(lfsr_q[3:0] ^ lfsr_q[63:60]);
	assign o_membus = ppm_membus_t'(lfsr_q[52:8]);
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps
`include "ppm_cfg.svh"
module tb_top;
	import ppm_pkg::*;
	localparam logic [31:0] RA [15] = '{`PPM_OFS_LATCH_TWO, `PPM_OFS_LATCH_THREE,
		`PPM_OFS_LATCH_FOUR, `PPM_OFS_LATCH_FIVE, `PPM_OFS_LATCH_SIX, `PPM_OFS_LATCH_NINE,
		`PPM_OFS_DIR_TWO, `PPM_OFS_DIR_THREE, `PPM_OFS_DIR_FOUR, `PPM_OFS_DIR_FIVE,
		`PPM_OFS_DIR_SIX, `PPM_OFS_DIR_NINE, `PPM_OFS_FSEL_TWO, `PPM_OFS_FSEL_THREE,
		`PPM_OFS_EXP_CODE};
	localparam logic [7:0] WM [15] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfe,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1e, 8'h1f, 8'h07};
	localparam logic [7:0] CODES [7] = '{8'h05, 8'h06, 8'h03, 8'h04, 8'h01, 8'h00, 8'h07};
	logic i_mclk, i_reset = 1'b1, i_boot_config_pin_a = 1'b0, i_boot_config_pin_b = 1'b0;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0, o_rdata;
	logic [3:0] i_wstrb = 4'h0, o_ext_irq_group_zero;
	logic [7:0] i_p2 = 8'h0, i_p3 = 8'h0, i_p4 = 8'h0, i_p5 = 8'h0, i_p6 = 8'h0, i_p9 = 8'h0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_nmi, o_ser_data_in;
	logic o_ser_clk_in, o_uart_rx_in, o_fetch_ok, fet;
	logic [1:0] o_bresp, o_rresp;
	logic [2:0] o_expansion_code_reg;
	ppm_pins_t o_p2, o_p3, o_p4, o_p5, o_p6, o_p9;
	ppm_periph_out_t i_periph;
	ppm_membus_t i_membus;
	logic [7:0] mdl [15];
	logic [31:0] seed = 32'ha20f_7e17;
	int bad_count = 0, cmp_count = 0;

	ppm_port_mux i_ppm_port_mux (.*);
	ppm_far_model i_ppm_far_model (.i_mclk(i_mclk), .i_reset(i_reset), .o_periph(i_periph),
		.o_membus(i_membus));

	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	always @(posedge i_mclk) begin
		i_p2 <= 8'(xs());
		i_p3 <= 8'(xs());
		{i_p4, i_p5, i_p6, i_p9} <= xs();
	end
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_pin(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [15:0] gp(input logic [7:0] l, d, ao, aoe, s);
		logic [7:0] oe;
		oe = (~d & ~s) | (aoe & s);
		return {((l & ~s) | (ao & s)) & oe, oe};
	endfunction
	function automatic logic [15:0] pv(input ppm_pins_t p);
		return {p.o & p.oe, p.oe};
	endfunction
	task automatic rst(input logic a);
		@(posedge i_mclk);
		i_reset <= 1'b1;
		i_boot_config_pin_a <= a;
		repeat (5) @(posedge i_mclk);
		i_reset <= 1'b0;
		@(posedge i_mclk);
		foreach (mdl[k]) mdl[k] = (k < 6) ? 8'h00 : (k < 12) ? 8'hff : {7'h0, k == 12};
		mdl[14] = a ? 8'h00 : 8'h07;
		fet = !a;
	endtask
	// ready is raised late at random so the slave has to hold its answer
	task automatic axw(input logic [31:0] a, input logic [7:0] v, output logic [1:0] r);
		int n, st;
		n = 0;
		st = 1 + int'(xs() % 3);
		@(posedge i_mclk);
		i_awaddr <= a;
		i_wdata <= {4{v}};
		i_wstrb <= 4'h1 << a[1:0];
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		do begin
			@(posedge i_mclk);
			n++;
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			if (n == st) i_bready <= 1'b1;
		end while (!(o_bvalid && i_bready));
		r = o_bresp;
		i_bready <= 1'b0;
	endtask
	task automatic axr(input logic [31:0] a, output logic [7:0] v, output logic [1:0] r);
		int n, st;
		n = 0;
		st = 1 + int'(xs() % 3);
		@(posedge i_mclk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		do begin
			@(posedge i_mclk);
			n++;
			if (o_arready) i_arvalid <= 1'b0;
			if (n == st) i_rready <= 1'b1;
		end while (!(o_rvalid && i_rready));
		v = 8'(o_rdata >> {a[1:0], 3'b000});
		r = o_rresp;
		i_rready <= 1'b0;
	endtask
	task automatic wr(input int i, input logic [7:0] v);
		logic [1:0] r;
		axw(RA[i], v, r);
		cmp_reg({6'h0, r}, 8'h00);
		mdl[i] = (v & WM[i]) | {7'h0, i == 6 || i == 12};
		if (i == 14 && mdl[14] == 8'h00) fet = 1'b0;
	endtask
	task automatic rd(input int i);
		logic [7:0] v;
		logic [1:0] r;
		axr(RA[i], v, r);
		cmp_reg(v, mdl[i]);
		cmp_reg({6'h0, r}, 8'h00);
	endtask
	task automatic pins_chk;
		ppm_membus_t m;
		ppm_periph_out_t f;
		logic [7:0] a, b, c, s, s6;
		@(negedge i_mclk);
		m = i_membus;
		f = i_periph;
		a = i_p2;
		b = i_p3;
		@(negedge i_mclk);
		c = mdl[14];
		s = (c >= 8'h03) ? 8'hff : 8'h00;
		s6 = (c == 8'h07) ? 8'hff : (c == 8'h06) ? 8'h3f : (c == 8'h05) ? 8'h03 : 8'h00;
		cmp_pin(pv(o_p2), gp(mdl[0], mdl[6], 8'h00, 8'h00, mdl[12]));
		cmp_pin(pv(o_p3), gp(mdl[1], mdl[7],
			{4'h0, f.uart_tx_out, f.ser_clk_out, 1'b0, f.ser_data_out},
			{5'h01, f.ser_clk_oe, 2'h1}, mdl[13]));
		cmp_pin(pv(o_p4), gp(mdl[2], mdl[8],
			m.muxed_addr_data[7:0], m.muxed_addr_data_oe[7:0], s));
		cmp_pin(pv(o_p5), gp(mdl[3], mdl[9],
			m.muxed_addr_data[15:8], m.muxed_addr_data_oe[15:8], s));
		cmp_pin(pv(o_p6), gp(mdl[4], mdl[10], m.upper_address_out, 8'hff, s6));
		cmp_pin(pv(o_p9), gp(mdl[5], mdl[11], {3'h0, m.address_latch_strobe_out,
			m.data_strobe_out, m.read_write_out, m.high_byte_enable_out,
			m.low_byte_enable_out}, 8'h1f, s & 8'h1f));
		cmp_pin({8'h0, o_nmi, o_ext_irq_group_zero, o_uart_rx_in, o_ser_data_in,
			o_ser_clk_in}, {8'h0, a[0], a[4:1] & mdl[12][4:1], mdl[13][4] ? b[4] : 1'b1,
			mdl[13][1] & b[1], mdl[13][2] & b[2]});
		cmp_pin({12'h0, o_fetch_ok, o_expansion_code_reg}, {12'h0, fet, c[2:0]});
	endtask
	initial begin
		logic [1:0] r;
		logic [7:0] v;
		rst(1'b0);
		for (int i = 0; i < 15; i++) rd(i);
		pins_chk;
		$display("test reset values done");
		wr(6, 8'h00);
		wr(12, 8'h00);
		wr(13, 8'hff);
		for (int i = 0; i < 40; i++) begin
			wr(int'(xs() % 14), 8'(xs()));
			if (i % 8 == 7) pins_chk;
		end
		for (int i = 0; i < 14; i++) rd(i);
		$display("test random access done");
		foreach (CODES[k]) begin
			wr(14, CODES[k]);
			rd(14);
			pins_chk;
		end
		$display("test expansion codes done");
		axw(32'hffff_f050, 8'h5a, r);
		cmp_reg({6'h0, r}, 8'h02);
		axr(32'hffff_f050, v, r);
		cmp_reg({6'h0, r}, 8'h02);
		for (int i = 0; i < 15; i++) rd(i);
		$display("test unmapped access done");
		rst(1'b1);
		rd(14);
		pins_chk;
		$display("test second reset done");
		close_out;
	end
	initial begin
		repeat (30000) @(posedge i_mclk);
		bad_count++;
		close_out;
	end
endmodule
